// ### rtl/cri_defs.svh
// Purpose: offsets, field positions and reset values of the flag block
// Assumes: 8-bit register port, byte-wide offsets
// Notes: included by the package, by cri_irq_flags and by the bench
`ifndef CRI_DEFS_SVH
`define CRI_DEFS_SVH
`define CRI_ADDR_W 8
`define CRI_DATA_W 8
`define CRI_OFS_CHG_FLAGS 8'h04
`define CRI_OFS_CHG_MASKS 8'h05
`define CRI_OFS_REG_FLAGS 8'h06
`define CRI_OFS_REG_MASKS 8'h07
`define CRI_OFS_TOP 8'h01
`define CRI_CHG_BITS 7
`define CRI_REG_BITS 4
`define CRI_CHG_FLAG_RST 7'h00
`define CRI_CHG_MASK_RST 7'h7f
`define CRI_REG_FLAG_RST 4'h0
`define CRI_REG_MASK_RST 8'hff
`define CRI_BIT_DEAD 6
`define CRI_BIT_ILIM 5
`define CRI_BIT_FAST 4
`define CRI_BIT_PREQ 3
`define CRI_BIT_BATT 2
`define CRI_BIT_VBAT 1
`define CRI_BIT_CHGOK 0
`define CRI_TOP_CHG 2
`define CRI_TOP_BUCK 1
`define CRI_TOP_LIN 0
`define CRI_BUCK_HI 3
`define CRI_BUCK_LO 2
`define CRI_LIN_HI 1
`define CRI_LIN_LO 0
`endif

// ### rtl/cri_pkg.sv
// Purpose: shared types of the charger and regulator flag block
// Assumes: cri_defs.svh gives the widths
// Notes: types only, numbers live in the header
`include "cri_defs.svh"
package cri_pkg;
  // one register port access
  typedef struct packed {
    logic wr;                         // write strobe
    logic [`CRI_ADDR_W-1:0] addr;     // register offset
    logic [`CRI_DATA_W-1:0] wdata;    // write data
  } cri_bus_s;
  // charger group event inputs, one cycle pulses or levels
  typedef struct packed {
    logic dead_timeout;               // dead-charge timer expired
    logic ilim_active;                // input current limiter active
    logic fast_timeout;               // fast-charge timer expired
    logic preq_timeout;               // pre-qual timer expired
    logic battery_attached_status;    // battery attached level
    logic vbat_good;                  // battery voltage good level
    logic charger_good;               // charger good level
  } cri_chg_in_s;
  // rail power-good levels
  typedef struct packed {
    logic buck1_power_good;           // buck 1 good
    logic buck2_power_good;           // buck 2 good
    logic linreg1_power_good;         // ldo 1 good
    logic linreg2_power_good;         // ldo 2 good
  } cri_rail_in_s;
endpackage : cri_pkg

// ### rtl/cri_change_det.sv
// Purpose: flags a change on a set of status levels
// Assumes: levels synchronous to the clock
// Notes: the first sample after reset is taken as the baseline
`timescale 1ns/100ps
module cri_change_det import cri_pkg::*; #(
  parameter int WIDTH = 4               // number of levels watched
) (
  input wire logic i_ref_clk,           // system clock
  input wire logic i_reset_n,           // sync reset, active low
  input wire logic [WIDTH-1:0] i_level, // levels watched
  output logic [WIDTH-1:0] o_change     // one pulse per edge
);
  // all state in one struct
  typedef struct packed {
    logic armed;                        // baseline captured
    logic [WIDTH-1:0] last;             // previous sample
  } cri_det_s;
  cri_det_s st, next_st;

  // no edge is reported before a baseline exists, so reset is quiet
  always_comb begin
    next_st = st;
    next_st.armed = 1'b1;
    next_st.last = i_level;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // either direction counts
  assign o_change = st.armed ? (st.last ^ i_level) : '0;
endmodule : cri_change_det

// ### rtl/cri_flag_bank.sv
// Purpose: sticky write-to-clear flags
// Assumes: clear is a write of ones to the flag positions
// Notes: a set in the clearing cycle wins
`timescale 1ns/100ps
module cri_flag_bank import cri_pkg::*; #(
  parameter int WIDTH = 4               // flags in the bank
) (
  input wire logic i_ref_clk,           // system clock
  input wire logic i_reset_n,           // sync reset, active low
  input wire logic [WIDTH-1:0] i_set,   // event pulses
  input wire logic [WIDTH-1:0] i_clear, // write-one clear bits
  output logic [WIDTH-1:0] o_flags      // latched flags
);
  typedef struct packed {
    logic [WIDTH-1:0] flags;            // sticky flags
  } cri_bank_s;
  cri_bank_s st, next_st;

  // only written bits drop; set overrides clear
  always_comb begin
    next_st = st;
    next_st.flags = (st.flags & ~i_clear) | i_set;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_flags = st.flags;

  // an event in the clearing cycle must survive the clear
  property p_set_wins;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      (|(i_set & i_clear)) |=> ((o_flags & $past(i_set)) == $past(i_set));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("flag lost when set met clear");
  // a flag may only drop where a one was written
  property p_clear_only;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      ##1 (((o_flags ^ $past(o_flags)) & $past(o_flags) & ~$past(i_clear))
      == '0);
  endproperty
  a_clear_only: assert property (p_clear_only)
    else $error("flag dropped without a clear");
endmodule : cri_flag_bank

// ### rtl/cri_irq_flags.sv
// Purpose: charger and regulator second-tier event flags and masks
// Assumes: byte register port, read data registered one cycle late
// Notes: feeds three summary bits of the top interrupt register
`timescale 1ns/100ps
`include "cri_defs.svh"
module cri_irq_flags import cri_pkg::*; (
  input wire logic i_ref_clk,            // system clock, 125 MHz
  input wire logic i_reset_n,            // sync reset, active low
  input wire cri_bus_s i_bus,            // register write/address
  input wire logic i_rd,                 // read strobe
  input wire cri_chg_in_s i_chg,         // charger events and levels
  input wire cri_rail_in_s i_rail,       // rail power-good levels
  output logic [`CRI_DATA_W-1:0] o_rdata, // read data, registered
  output logic o_rvalid,                 // read data valid pulse
  output logic o_charger_group_summary,  // top bit 2
  output logic o_buck_group_summary,     // top bit 1
  output logic o_linreg_group_summary    // top bit 0
);
  // all state of this level in one struct
  typedef struct packed {
    logic [`CRI_CHG_BITS-1:0] chg_masks;  // charger masks
    logic [`CRI_DATA_W-1:0] reg_masks;    // regulator masks, full byte
    logic [`CRI_DATA_W-1:0] rdata;        // read holding register
    logic rvalid;                         // read answer pulse
    logic [2:0] top;                      // registered summaries
  } cri_top_s;
  cri_top_s st, next_st;

  logic [2:0] chg_lvl_change;              // charger level edges
  logic [`CRI_REG_BITS-1:0] rail_change;   // rail good edges
  logic [`CRI_CHG_BITS-1:0] chg_set;       // charger set pulses
  logic [`CRI_CHG_BITS-1:0] chg_clr;       // charger clear bits
  logic [`CRI_REG_BITS-1:0] reg_clr;       // regulator clear bits
  logic [`CRI_CHG_BITS-1:0] chg_flags;     // charger flags
  logic [`CRI_REG_BITS-1:0] reg_flags;     // regulator flags
  logic [2:0] top_now;                     // summaries this cycle

  // write decode helper, used for each of the four writable registers
  function automatic logic hit(input cri_bus_s b,
                               input logic [`CRI_ADDR_W-1:0] ofs);
    hit = b.wr && (b.addr == ofs);
  endfunction : hit

  // status levels that report changes
  cri_change_det #(.WIDTH(3)) u_chg_det (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_level({i_chg.battery_attached_status, i_chg.vbat_good,
              i_chg.charger_good}),
    .o_change(chg_lvl_change)
  );

  cri_change_det #(.WIDTH(`CRI_REG_BITS)) u_rail_det (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_level({i_rail.buck1_power_good, i_rail.buck2_power_good,
              i_rail.linreg1_power_good, i_rail.linreg2_power_good}),
    .o_change(rail_change)
  );

  // charger set vector; limiter level keeps re-setting while active
  always_comb begin
    chg_set = '0;
    chg_set[`CRI_BIT_DEAD] = i_chg.dead_timeout;
    chg_set[`CRI_BIT_ILIM] = i_chg.ilim_active;
    chg_set[`CRI_BIT_FAST] = i_chg.fast_timeout;
    chg_set[`CRI_BIT_PREQ] = i_chg.preq_timeout;
    chg_set[`CRI_BIT_BATT] = chg_lvl_change[`CRI_BIT_BATT];
    chg_set[`CRI_BIT_VBAT] = chg_lvl_change[`CRI_BIT_VBAT];
    chg_set[`CRI_BIT_CHGOK] = chg_lvl_change[`CRI_BIT_CHGOK];
  end

  // a write clears the flags written as one; reserved bit 7 ignored
  assign chg_clr = hit(i_bus, `CRI_OFS_CHG_FLAGS) ?
                   i_bus.wdata[`CRI_CHG_BITS-1:0] : '0;
  assign reg_clr = hit(i_bus, `CRI_OFS_REG_FLAGS) ?
                   i_bus.wdata[`CRI_REG_BITS-1:0] : '0;

  cri_flag_bank #(.WIDTH(`CRI_CHG_BITS)) u_chg_bank (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_set(chg_set),
    .i_clear(chg_clr),
    .o_flags(chg_flags)
  );

  cri_flag_bank #(.WIDTH(`CRI_REG_BITS)) u_reg_bank (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_set(rail_change),
    .i_clear(reg_clr),
    .o_flags(reg_flags)
  );

  // summaries: any set flag whose mask is zero
  always_comb begin
    top_now = '0;
    top_now[`CRI_TOP_CHG] = |(chg_flags & ~st.chg_masks);
    top_now[`CRI_TOP_BUCK] = |(reg_flags[`CRI_BUCK_HI:`CRI_BUCK_LO]
      & ~st.reg_masks[`CRI_BUCK_HI:`CRI_BUCK_LO]);
    top_now[`CRI_TOP_LIN] = |(reg_flags[`CRI_LIN_HI:`CRI_LIN_LO]
      & ~st.reg_masks[`CRI_LIN_HI:`CRI_LIN_LO]);
  end

  // mask storage and the read path
  always_comb begin
    next_st = st;
    next_st.rvalid = i_rd;
    next_st.top = top_now;
    if (hit(i_bus, `CRI_OFS_CHG_MASKS)) begin
      next_st.chg_masks = i_bus.wdata[`CRI_CHG_BITS-1:0];
    end
    if (hit(i_bus, `CRI_OFS_REG_MASKS)) begin
      next_st.reg_masks = i_bus.wdata;
    end
    if (i_rd) begin
      case (i_bus.addr)
        `CRI_OFS_TOP: next_st.rdata = {5'h00, top_now};
        `CRI_OFS_CHG_FLAGS: next_st.rdata = {1'b0, chg_flags};
        `CRI_OFS_CHG_MASKS: next_st.rdata = {1'b0, st.chg_masks};
        `CRI_OFS_REG_FLAGS: next_st.rdata = {4'h0, reg_flags};
        `CRI_OFS_REG_MASKS: next_st.rdata = st.reg_masks;
        default: next_st.rdata = '0; // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      st.chg_masks <= `CRI_CHG_MASK_RST;
      st.reg_masks <= `CRI_REG_MASK_RST;
      st.rdata <= '0;
      st.rvalid <= 1'b0;
      st.top <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_rvalid = st.rvalid;
  assign o_charger_group_summary = st.top[`CRI_TOP_CHG];
  assign o_buck_group_summary = st.top[`CRI_TOP_BUCK];
  assign o_linreg_group_summary = st.top[`CRI_TOP_LIN];

  // checks
  sequence s_dead_evt;
    i_chg.dead_timeout;
  endsequence
  property p_dead;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      s_dead_evt |=> chg_flags[`CRI_BIT_DEAD];
  endproperty
  a_dead: assert property (p_dead) else $error("dead flag not set");
  property p_ilim;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      i_chg.ilim_active |=> chg_flags[`CRI_BIT_ILIM];
  endproperty
  a_ilim: assert property (p_ilim) else $error("ilim flag not set");
  property p_charger_sum;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      (|(chg_flags & ~st.chg_masks)) |=> o_charger_group_summary;
  endproperty
  a_charger_sum: assert property (p_charger_sum)
    else $error("charger summary missing");
  property p_sum_low;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      !(|(chg_flags & ~st.chg_masks)) |=> !o_charger_group_summary;
  endproperty
  a_sum_low: assert property (p_sum_low)
    else $error("charger summary stuck");
  property p_buck_sum;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      ##1 o_buck_group_summary
      == $past(|(reg_flags[`CRI_BUCK_HI:`CRI_BUCK_LO]
      & ~st.reg_masks[`CRI_BUCK_HI:`CRI_BUCK_LO]));
  endproperty
  a_buck_sum: assert property (p_buck_sum)
    else $error("buck summary wrong");
  property p_masked;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      (&st.chg_masks) |=> !o_charger_group_summary;
  endproperty
  a_masked: assert property (p_masked) else $error("mask ignored");
  property p_mask_rw;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      hit(i_bus, `CRI_OFS_CHG_MASKS) |=>
      st.chg_masks == $past(i_bus.wdata[`CRI_CHG_BITS-1:0]);
  endproperty
  a_mask_rw: assert property (p_mask_rw) else $error("mask not stored");
  property p_rail;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      (|rail_change) |=> ((reg_flags & $past(rail_change))
      == $past(rail_change));
  endproperty
  a_rail: assert property (p_rail) else $error("rail flag missed");
  // timer expiries latch on the cycle after the pulse
  property p_fast;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      i_chg.fast_timeout |=> chg_flags[`CRI_BIT_FAST];
  endproperty
  a_fast: assert property (p_fast) else $error("fast flag not set");
  property p_preq;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      i_chg.preq_timeout |=> chg_flags[`CRI_BIT_PREQ];
  endproperty
  a_preq: assert property (p_preq) else $error("preq flag not set");
  // a level edge counts only once the detector holds its baseline,
  // taken on the first edge after reset; the reset qualifier keeps
  // these checks quiet across that one cycle
  property p_batt;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      $past(i_reset_n) && $changed(i_chg.battery_attached_status)
      |=> chg_flags[`CRI_BIT_BATT];
  endproperty
  a_batt: assert property (p_batt) else $error("battery flag missed");
  property p_vbat;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      $past(i_reset_n) && $changed(i_chg.vbat_good)
      |=> chg_flags[`CRI_BIT_VBAT];
  endproperty
  a_vbat: assert property (p_vbat) else $error("vbat flag missed");
  property p_chgok;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      $past(i_reset_n) && $changed(i_chg.charger_good)
      |=> chg_flags[`CRI_BIT_CHGOK];
  endproperty
  a_chgok: assert property (p_chgok)
    else $error("charger good flag missed");
  // ldo summary follows its two unmasked flags one cycle late
  property p_lin_sum;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      ##1 o_linreg_group_summary
      == $past(|(reg_flags[`CRI_LIN_HI:`CRI_LIN_LO]
      & ~st.reg_masks[`CRI_LIN_HI:`CRI_LIN_LO]));
  endproperty
  a_lin_sum: assert property (p_lin_sum)
    else $error("ldo summary wrong");
  // read path: charger summary at its bit, reserved bit 7 reads zero
  property p_top_read;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      i_rd && (i_bus.addr == `CRI_OFS_TOP) |=>
      o_rdata[`CRI_TOP_CHG] == $past(|(chg_flags & ~st.chg_masks));
  endproperty
  a_top_read: assert property (p_top_read)
    else $error("top register misplaced");
  property p_cmask_read;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      i_rd && (i_bus.addr == `CRI_OFS_CHG_MASKS) |=>
      o_rdata == {1'b0, $past(st.chg_masks)};
  endproperty
  a_cmask_read: assert property (p_cmask_read)
    else $error("charger mask read wrong");
  property p_rsvd_read;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      i_rd && (i_bus.addr == `CRI_OFS_CHG_FLAGS) |=>
      !o_rdata[`CRI_DATA_W-1];
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("reserved flag bit set");
  // a clearing write drops every written flag that no event re-set
  property p_chg_clear;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      hit(i_bus, `CRI_OFS_CHG_FLAGS) |=>
      (chg_flags & $past(i_bus.wdata[`CRI_CHG_BITS-1:0] & ~chg_set)) == '0;
  endproperty
  a_chg_clear: assert property (p_chg_clear)
    else $error("written flag not cleared");
  property p_reg_clear;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      hit(i_bus, `CRI_OFS_REG_FLAGS) |=>
      (reg_flags & $past(i_bus.wdata[`CRI_REG_BITS-1:0] & ~rail_change))
      == '0;
  endproperty
  a_reg_clear: assert property (p_reg_clear)
    else $error("written rail flag not cleared");
  // no disable here: these look at the cycle after reset is taken
  property p_rst_chg;
    @(posedge i_ref_clk)
      !i_reset_n |=> (st.chg_masks == `CRI_CHG_MASK_RST)
      && (chg_flags == '0);
  endproperty
  a_rst_chg: assert property (p_rst_chg)
    else $error("charger reset values wrong");
  property p_rst_rail;
    @(posedge i_ref_clk)
      !i_reset_n |=> (st.reg_masks == `CRI_REG_MASK_RST)
      && (reg_flags == '0);
  endproperty
  a_rst_rail: assert property (p_rst_rail)
    else $error("rail reset values wrong");
endmodule : cri_irq_flags

// ### bench/cri_host_model.sv
// Purpose: host software side of the flag block's register port
// Assumes: one access at a time, read data one cycle after the strobe
// Notes: released lines show inverted last values, never stale ones
`timescale 1ns/100ps
module cri_host_model import cri_pkg::*; (
  input wire logic i_ref_clk, // system clock
  input wire logic [7:0] i_rdata, // read data from the block
  input wire logic i_rvalid, // read data valid pulse
  output cri_bus_s o_bus, // write strobe, address, data
  output logic o_rd // read strobe
);
  // idle port at time zero
  initial begin
    o_bus = '{wr: 1'b0, addr: 8'h00, wdata: 8'h00};
    o_rd = 1'b0;
  end

  // one write: held across the taking edge, released after it
  task automatic write_reg(input logic [7:0] addr,
                           input logic [7:0] data);
    @(posedge i_ref_clk);
    #1;
    o_bus = '{wr: 1'b1, addr: addr, wdata: data};
    @(posedge i_ref_clk);
    #1;
    o_bus = '{wr: 1'b0, addr: ~addr, wdata: ~data};
  endtask : write_reg

  // one read: strobe for a single edge, answer waited for a few cycles
  task automatic read_reg(input logic [7:0] addr,
                          output logic [7:0] data);
    int n;
    @(posedge i_ref_clk);
    #1;
    o_bus.addr = addr;
    o_rd = 1'b1;
    @(posedge i_ref_clk);
    #1;
    o_rd = 1'b0;
    o_bus.addr = ~addr;
    n = 0;
    // bounded, so a dead read shows up as unknown data
    while (i_rvalid !== 1'b1 && n < 4) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    data = (i_rvalid === 1'b1) ? i_rdata : 8'hxx;
  endtask : read_reg
endmodule : cri_host_model

// ### bench/test_cri_irq_flags.sv
// Purpose: self-checking bench of the charger and regulator flags
// Assumes: host model does all register traffic
// Notes: event and status inputs are driven here, 1 ns after the edge
`timescale 1ns/100ps
`include "cri_defs.svh"
module test_cri_irq_flags import cri_pkg::*; ;
  localparam logic [7:0] ofs_cf = `CRI_OFS_CHG_FLAGS; // charger flags
  localparam logic [7:0] ofs_cm = `CRI_OFS_CHG_MASKS; // charger masks
  localparam logic [7:0] ofs_rf = `CRI_OFS_REG_FLAGS; // rail flags
  localparam logic [7:0] ofs_rm = `CRI_OFS_REG_MASKS; // rail masks
  localparam logic [7:0] ofs_top = `CRI_OFS_TOP; // summary register
  logic i_ref_clk; // 125 MHz clock
  logic i_reset_n; // sync reset, active low
  cri_bus_s bus; // host request
  logic rd; // host read strobe
  cri_chg_in_s chg; // charger events and levels
  cri_rail_in_s rail; // rail good levels
  logic [7:0] rdata; // read data
  logic rvalid; // read valid
  logic sum_chg; // charger summary
  logic sum_buck; // buck summary
  logic sum_lin; // ldo summary
  int num_errors; // mismatches
  int tests_run; // comparisons

  cri_irq_flags i_cri_irq_flags (.i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n), .i_bus(bus), .i_rd(rd), .i_chg(chg),
    .i_rail(rail), .o_rdata(rdata), .o_rvalid(rvalid),
    .o_charger_group_summary(sum_chg), .o_buck_group_summary(sum_buck),
    .o_linreg_group_summary(sum_lin));
  cri_host_model i_cri_host_model (.i_ref_clk(i_ref_clk),
    .i_rdata(rdata), .i_rvalid(rvalid), .o_bus(bus), .o_rd(rd));

  // clock, 8 ns period
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic chk_byte(input string what, input logic [7:0] exp,
                          input logic [7:0] seen);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk_byte

  task automatic chk_bit(input string what, input logic exp,
                         input logic seen);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", what, exp, seen);
    end
  endtask : chk_bit

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    i_cri_host_model.write_reg(a, d);
  endtask : reg_wr

  task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] got;
    i_cri_host_model.read_reg(a, got);
    chk_byte($sformatf("register %h", a), exp, got);
  endtask : reg_chk

  // summaries settle one cycle after a flag or mask change
  task automatic sums(input logic c, input logic b, input logic l);
    repeat (3) @(posedge i_ref_clk);
    #1;
    chk_bit("charger summary", c, sum_chg);
    chk_bit("buck summary", b, sum_buck);
    chk_bit("ldo summary", l, sum_lin);
  endtask : sums

  // timers pulse for one cycle, status levels simply toggle
  task automatic fire_chg(input int b);
    @(posedge i_ref_clk);
    #1;
    if (b > 2) begin
      chg[b] = 1'b1;
      @(posedge i_ref_clk);
      #1;
      chg[b] = 1'b0;
    end else
      chg[b] = ~chg[b];
    repeat (3) @(posedge i_ref_clk);
  endtask : fire_chg

  // hang guard, far beyond the few hundred cycles the tests take
  initial begin
    #200000;
    num_errors++;
    $display("watchdog expired");
    summarize();
  end

  initial begin
    num_errors = 0;
    tests_run = 0;
    i_reset_n = 1'b0;
    chg = '0;
    rail = '0;
    repeat (4) @(posedge i_ref_clk);
    #1 i_reset_n = 1'b1;
    // let the change detectors take their baseline
    repeat (3) @(posedge i_ref_clk);
    reg_chk(ofs_cf, 8'h00);
    reg_chk(ofs_cm, 8'h7f);
    reg_chk(ofs_rf, 8'h00);
    reg_chk(ofs_rm, 8'hff);
    reg_chk(ofs_top, 8'h00);
    reg_chk(8'h08, 8'h00);
    sums(1'b0, 1'b0, 1'b0);
    // masks are plain storage, reserved charger bit reads 0
    reg_wr(ofs_cm, 8'haa);
    reg_chk(ofs_cm, 8'h2a);
    reg_wr(ofs_rm, 8'h5a);
    reg_chk(ofs_rm, 8'h5a);
    reg_wr(ofs_rm, 8'hff);
    reg_wr(ofs_cm, 8'h7f);
    // two passes so every status level goes both ways
    for (int p = 0; p < 2; p++)
      for (int b = 0; b < 7; b++) begin
        fire_chg(b);
        reg_chk(ofs_cf, 8'h01 << b);
        sums(1'b0, 1'b0, 1'b0);
        reg_wr(ofs_cm, 8'h7f ^ (8'h01 << b));
        sums(1'b1, 1'b0, 1'b0);
        reg_chk(ofs_top, 8'h04);
        reg_wr(ofs_cf, 8'h7f ^ (8'h01 << b));
        reg_chk(ofs_cf, 8'h01 << b);
        reg_wr(ofs_cf, 8'h01 << b);
        sums(1'b0, 1'b0, 1'b0);
        reg_chk(ofs_cf, 8'h00);
        reg_wr(ofs_cm, 8'h7f);
      end
    // rail good changes feed buck and ldo summaries
    for (int b = 0; b < 4; b++) begin
      @(posedge i_ref_clk);
      #1 rail[b] = ~rail[b];
      repeat (3) @(posedge i_ref_clk);
      reg_chk(ofs_rf, 8'h01 << b);
      reg_wr(ofs_rm, 8'hff ^ (8'h01 << b));
      sums(1'b0, b > 1, b < 2);
      reg_chk(ofs_top, (b > 1) ? 8'h02 : 8'h01);
      reg_wr(ofs_rf, 8'h01 << b);
      sums(1'b0, 1'b0, 1'b0);
      reg_chk(ofs_rf, 8'h00);
      reg_wr(ofs_rm, 8'hff);
    end
    // partial clear keeps the summary, event beats a clear
    reg_wr(ofs_cm, 8'h00);
    fire_chg(6);
    fire_chg(4);
    reg_wr(ofs_cf, 8'h10);
    reg_chk(ofs_cf, 8'h40);
    sums(1'b1, 1'b0, 1'b0);
    fork
      reg_wr(ofs_cf, 8'h40);
      fire_chg(6);
    join
    reg_chk(ofs_cf, 8'h40);
    reg_wr(ofs_cf, 8'h40);
    sums(1'b0, 1'b0, 1'b0);
    // second reset in mid-run: masks back to ones, flags and sums zero
    fire_chg(5);
    sums(1'b1, 1'b0, 1'b0);
    @(posedge i_ref_clk);
    #1 i_reset_n = 1'b0;
    repeat (4) @(posedge i_ref_clk);
    #1 i_reset_n = 1'b1;
    repeat (3) @(posedge i_ref_clk);
    reg_chk(ofs_cf, 8'h00);
    reg_chk(ofs_cm, 8'h7f);
    reg_chk(ofs_rf, 8'h00);
    reg_chk(ofs_rm, 8'hff);
    sums(1'b0, 1'b0, 1'b0);
    summarize();
  end
endmodule : test_cri_irq_flags
